// ### rtl/tbd_pkg.sv
// Purpose: shared constants for the two-bank dram strobe controller pair
// Assumes: one 25 MHz clock, both ends synchronous to it
// Notes:   config layout and cycle figures below are shared by both ends
//
// Contract
// - controller drives strobes, address, refresh rows
// - program controller by i/o before accesses
// - config value rides address bits 12..3
// - top address config input held low
// - two-bank mode drives all four row strobes together
// - row request drops both banks' strobes together
// - bank 1 column strobes gated separately
// - options and low address give byte enables
// - global enable gates, byte enables choose strobes
// - byte enables plus state give bank1 enables
// - unselected write lanes get no column strobe
// - every read strobes all four lanes
// - page mode pulses per-bank strobe enables
// - column strobes suppressed during refresh
// - mux select low row, high column
// - address latch transparent while enable high
// - init mode rising load edge stores config
// - read/write mode falling edge steps column
// - latch enable low while column steps
// - column clock is OR of bank1 strobes
// - cache mode compares row and bank, flags hit
// - hit takes three cycles, miss six
// - refresh wins ties with accesses (program request wins over it), suspends bursts
package tbd_pkg;

   // -----------------------------------------------------------------
   // address layout (word address, bit 0 picks the interleaved bank)
   // -----------------------------------------------------------------
   localparam int ADDR_W   = 22;
   localparam int ROW_W    = 10;
   localparam int COL_W    = 10;
   localparam int CFG_W    = 11;
   localparam int LANES    = 4;
   localparam int RFR_W    = 9;
   localparam int COL_LSB  = 1;
   localparam int ROW_LSB  = 11;
   localparam int BANK_BIT = 21;
   localparam int IBANK_BIT = 0;

   // -----------------------------------------------------------------
   // configuration register field positions
   // -----------------------------------------------------------------
   localparam int CFG_TWO_BANK  = 1;
   localparam int CFG_CACHE     = 2;
   localparam int CFG_ROW_ONLY  = 5;
   localparam int CFG_BYTE_DEC  = 6;
   localparam int CFG_EXT_TIME  = 7;
   localparam logic [12:0] CFG_PATTERN = 13'h0730;
   localparam logic [CFG_W-1:0] CFG_RESET = 11'h000;

   // -----------------------------------------------------------------
   // mode control encodings
   // -----------------------------------------------------------------
   localparam logic [1:0] MODE_INIT = 2'h3;
   localparam logic [1:0] MODE_RW   = 2'h2;

   // -----------------------------------------------------------------
   // access option encodings
   // -----------------------------------------------------------------
   localparam logic [2:0] OPT_WORD = 3'h0;
   localparam logic [2:0] OPT_BYTE = 3'h1;
   localparam logic [2:0] OPT_HALF = 3'h2;

   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_NS        = 40;
   localparam int REFR_ACT_NS   = 80;
   localparam int REFR_CYC      = (REFR_ACT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [1:0] REFR_CNT = 2'(REFR_CYC - 1);

   typedef enum logic [3:0] {
      ST_IDLE   = 4'b0000,
      ST_PROG   = 4'b0001,
      ST_PLOAD  = 4'b0010,
      ST_LATCH  = 4'b0011,
      ST_CHECK  = 4'b0100,
      ST_PRECH  = 4'b0101,
      ST_ROW    = 4'b0110,
      ST_MUXC   = 4'b0111,
      ST_STROBE = 4'b1000,
      ST_GAP    = 4'b1001,
      ST_RCLOSE = 4'b1010,
      ST_REFR   = 4'b1011
   } tbd_state_type;

endpackage

// ### rtl/tbd_link_if.sv
// Purpose: pins between the strobe controller and its control logic
// Assumes: all signals synchronous to clk
// Notes:   one modport per end, no clocking block
`timescale 1ns/1ps
`default_nettype none
interface tbd_link_if;
   import tbd_pkg::*;
   logic                row_strobe_request_in;
   logic                column_strobe_global_enable;
   logic [LANES-1:0]    column_strobe_byte_enables;
   logic                row_column_mux_select;
   logic                addr_latch_enable;
   logic                load_or_column_clock;
   logic [1:0]          mode_control_inputs;
   logic [CFG_W-1:0]    address_config_inputs;
   logic [1:0]          bank_select;
   logic                refresh_cycle;
   logic [ADDR_W-1:0]   cpu_addr;
   logic                row_match_hit;

   modport ctrl (
      input  row_strobe_request_in, column_strobe_global_enable,
      input  column_strobe_byte_enables, row_column_mux_select,
      input  addr_latch_enable, load_or_column_clock,
      input  mode_control_inputs, address_config_inputs,
      input  bank_select, refresh_cycle, cpu_addr,
      output row_match_hit
   );
   modport logic_end (
      output row_strobe_request_in, column_strobe_global_enable,
      output column_strobe_byte_enables, row_column_mux_select,
      output addr_latch_enable, load_or_column_clock,
      output mode_control_inputs, address_config_inputs,
      output bank_select, refresh_cycle, cpu_addr,
      input  row_match_hit
   );
endinterface
`default_nettype wire

// ### rtl/tbd_lane_dec.sv
// Purpose: byte lane enable decode from access options and low address
// Assumes: combinational, used inside the control logic end
// Notes:   reads always return the full word
`timescale 1ns/1ps
`default_nettype none
module tbd_lane_dec
   import tbd_pkg::*;
(
   // access description
   input  wire logic [2:0]        opt,
   input  wire logic [1:0]        low_addr,
   input  wire logic              is_write,
   // decoded lanes
   output logic [LANES-1:0]       byte_lane_enables
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   // lane 0 is the low byte of the word
   always_comb
   begin
      byte_lane_enables = 4'hf;
      if (is_write)
      begin
         case (opt)
            OPT_BYTE: byte_lane_enables = 4'(4'h1 << low_addr);
            OPT_HALF: byte_lane_enables = low_addr[1] ? 4'hc : 4'h3;
            default:  byte_lane_enables = 4'hf;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### rtl/tbd_dram_ctrl.sv
// Purpose: configurable dram controller end: strobes, address mux, hit
// Assumes: control logic end keeps bank select low and sequences modes
// Notes:   load/column clock edges are detected on the sampled level
`timescale 1ns/1ps
`default_nettype none
module tbd_dram_ctrl
   import tbd_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // link to control logic
   tbd_link_if.ctrl               lnk,
   // dram array pins
   output logic [LANES-1:0]       ras_n_r,
   output logic [LANES-1:0]       cas_n_r,
   output logic [ROW_W-1:0]       dram_addr_r,
   // status
   output logic [CFG_W-1:0]       config_r
);
   logic [ADDR_W-1:0] latch_r;
   logic [COL_W-1:0]  col_r;
   logic [RFR_W-1:0]  rfr_row_r;
   logic [ROW_W-1:0]  prev_row_r;
   logic              prev_bank_r;
   logic              prev_valid_r;
   logic              lcc_d_r;
   logic              ras_d_r;
   logic              hit_r;
   logic [ADDR_W-1:0] cur_addr;
   logic [ROW_W-1:0]  cur_row;
   logic              cur_bank;
   logic              lcc_rise;
   logic              lcc_fall;

   assign lnk.row_match_hit = hit_r;
   // transparent latch seen as current address
   assign cur_addr = lnk.addr_latch_enable ? lnk.cpu_addr : latch_r;
   assign cur_row  = cur_addr[ROW_LSB +: ROW_W];
   assign cur_bank = cur_addr[BANK_BIT];
   assign lcc_rise = lnk.load_or_column_clock & ~lcc_d_r;
   assign lcc_fall = ~lnk.load_or_column_clock & lcc_d_r;

   // ----------------------------------------------------------------
   // edge history
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lcc_d_r <= 1'b0;
         ras_d_r <= 1'b0;
      end
      else
      begin
         lcc_d_r <= lnk.load_or_column_clock;
         ras_d_r <= lnk.row_strobe_request_in;
      end
   end

   // ----------------------------------------------------------------
   // configuration register
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         config_r <= CFG_RESET;
      else if (lnk.mode_control_inputs == MODE_INIT && lcc_rise)
         config_r <= lnk.address_config_inputs;
   end

   // ----------------------------------------------------------------
   // address latch and column counter
   // ----------------------------------------------------------------
   // latch follows input while enable is high, holds when low
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         latch_r <= '0;
      else if (lnk.addr_latch_enable)
         latch_r <= lnk.cpu_addr;
   end

   // counter steps only with the latch closed; an open latch reloads
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         col_r <= '0;
      else if (lnk.addr_latch_enable)
         col_r <= lnk.cpu_addr[COL_LSB +: COL_W];
      else if (lnk.mode_control_inputs == MODE_RW && lcc_fall)
         col_r <= col_r + 10'h001;
   end

   // ----------------------------------------------------------------
   // refresh row counter
   // ----------------------------------------------------------------
   // steps as a refresh row strobe opens; stepping on the close would
   // also count a normal row that refresh shuts at its start
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rfr_row_r <= '0;
      else if (lnk.refresh_cycle && lnk.row_strobe_request_in && !ras_d_r)
         rfr_row_r <= rfr_row_r + 9'h001;
   end

   // ----------------------------------------------------------------
   // multiplexed dram address
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         dram_addr_r <= '0;
      else if (lnk.refresh_cycle)
         dram_addr_r <= {1'b0, rfr_row_r};
      else if (lnk.row_column_mux_select)
         dram_addr_r <= col_r;
      else
         dram_addr_r <= cur_row;
   end

   // ----------------------------------------------------------------
   // row and column strobes, one per lane
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         // two-bank mode opens every row group at once so both banks
         // can interleave; otherwise bank select picks one group
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               ras_n_r[g] <= 1'b1;
            else if (config_r[CFG_TWO_BANK])
               ras_n_r[g] <= ~lnk.row_strobe_request_in;
            else
               ras_n_r[g] <= ~(lnk.row_strobe_request_in &&
                               lnk.bank_select == 2'(g));
         end

         // global enable times, byte enable picks, refresh kills
         always_ff @(posedge clk or posedge sys_rst)
         begin
            if (sys_rst)
               cas_n_r[g] <= 1'b1;
            else
               cas_n_r[g] <= ~(lnk.column_strobe_global_enable &&
                               lnk.column_strobe_byte_enables[g] &&
                               !(lnk.refresh_cycle &&
                                 config_r[CFG_ROW_ONLY]));
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // cache row comparison
   // ----------------------------------------------------------------
   // remember row and bank opened by each non-refresh row strobe
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         prev_row_r   <= '0;
         prev_bank_r  <= 1'b0;
         prev_valid_r <= 1'b0;
      end
      else if (lnk.refresh_cycle)
         prev_valid_r <= 1'b0;
      else if (lnk.row_strobe_request_in && !ras_d_r)
      begin
         prev_row_r   <= cur_row;
         prev_bank_r  <= cur_bank;
         prev_valid_r <= 1'b1;
      end
   end

   // hit needs cache mode and an open row; one cycle behind the address
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         hit_r <= 1'b0;
      else
         hit_r <= config_r[CFG_CACHE] && prev_valid_r &&
                  lnk.row_strobe_request_in &&
                  cur_row == prev_row_r &&
                  cur_bank == prev_bank_r;
   end
endmodule
`default_nettype wire

// ### rtl/tbd_mem_seq.sv
// Purpose: control logic end: programming, sequencing, bank 1 strobes
// Assumes: requester holds its request until acknowledged
// Notes:   refresh taken between beats; a single access is never split
`timescale 1ns/1ps
`default_nettype none
module tbd_mem_seq
   import tbd_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // link to controller
   tbd_link_if.logic_end          lnk,
   // requester side
   input  wire logic              program_req,
   input  wire logic              refresh_req,
   input  wire logic              acc_req,
   input  wire logic              acc_write,
   input  wire logic [2:0]        acc_opt,
   input  wire logic [ADDR_W+1:0] acc_addr,
   input  wire logic [3:0]        acc_beats,
   output logic                   acc_ack_r,
   output logic                   programmed_r,
   output logic                   refresh_ack_r,
   output logic [LANES-1:0]       bank1_strobe_enables_r
);
   tbd_state_type     st_r;
   logic [3:0]        beats_r;
   logic              bank_r;
   logic              rfr_pend_r;
   logic [1:0]        rcnt_r;
   logic [LANES-1:0]  byte_lane_enables;
   logic [LANES-1:0]  lanes_r;
   logic              more;

   tbd_lane_dec u_dec (
      .opt               (acc_opt),
      .low_addr          (acc_addr[1:0]),
      .is_write          (acc_write),
      .byte_lane_enables (byte_lane_enables)
   );

   assign more = beats_r != 4'h0;

   // fixed straps of this board
   assign lnk.bank_select           = 2'h0;
   assign lnk.address_config_inputs = {1'b0, CFG_PATTERN[12:3]};
   // column clock from bank 1 strobes, so the shared address holds
   assign lnk.load_or_column_clock  = (st_r == ST_PLOAD) |
                                      (|bank1_strobe_enables_r);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st_r         <= ST_IDLE;
         programmed_r <= 1'b0;
         beats_r      <= 4'h0;
         bank_r       <= 1'b0;
         lanes_r      <= 4'h0;
         rcnt_r       <= 2'h0;
      end
      else
      begin
         case (st_r)
            ST_IDLE:
               if (program_req)
                  st_r <= ST_PROG;
               else if (rfr_pend_r || refresh_req)
                  st_r <= ST_RCLOSE;
               else if (acc_req && programmed_r)
               begin
                  beats_r <= acc_beats;
                  bank_r  <= acc_addr[IBANK_BIT + 2];
                  lanes_r <= byte_lane_enables;
                  st_r    <= ST_LATCH;
               end
            ST_PROG:
               st_r <= ST_PLOAD;
            ST_PLOAD:
            begin
               programmed_r <= 1'b1;
               st_r         <= ST_IDLE;
            end
            ST_LATCH:
               st_r <= ST_CHECK;
            ST_CHECK:
               st_r <= lnk.row_match_hit ? ST_STROBE : ST_PRECH;
            ST_PRECH:
               st_r <= ST_ROW;
            ST_ROW:
               st_r <= ST_MUXC;
            ST_MUXC:
               st_r <= ST_STROBE;
            ST_STROBE:
               st_r <= ST_GAP;
            ST_GAP:
               if (more && rfr_pend_r)
                  st_r <= ST_RCLOSE;
               else if (more)
               begin
                  beats_r <= beats_r - 4'h1;
                  bank_r  <= ~bank_r;
                  st_r    <= ST_STROBE;
               end
               else
                  st_r <= ST_IDLE;
            ST_RCLOSE:
            begin
               rcnt_r <= REFR_CNT;
               st_r   <= ST_REFR;
            end
            ST_REFR:
               if (rcnt_r != 2'h0)
                  rcnt_r <= rcnt_r - 2'h1;
               else if (more)
               begin
                  // the beat before the cut is done, so step past it
                  beats_r <= beats_r - 4'h1;
                  bank_r  <= ~bank_r;
                  st_r    <= ST_PRECH;
               end
               else
                  st_r <= ST_IDLE;
            default:
               st_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // refresh request capture, set beats clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rfr_pend_r <= 1'b0;
      else if (refresh_req)
         rfr_pend_r <= 1'b1;
      else if (st_r == ST_RCLOSE)
         rfr_pend_r <= 1'b0;
   end

   // ----------------------------------------------------------------
   // link drive
   // ----------------------------------------------------------------
   // row stays open between accesses so cache hits skip precharge
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         lnk.row_strobe_request_in       <= 1'b0;
         lnk.row_column_mux_select       <= 1'b0;
         lnk.addr_latch_enable           <= 1'b0;
         lnk.mode_control_inputs         <= MODE_RW;
         lnk.refresh_cycle               <= 1'b0;
         lnk.column_strobe_global_enable <= 1'b0;
         lnk.column_strobe_byte_enables  <= 4'h0;
         lnk.cpu_addr                    <= '0;
      end
      else
      begin
         lnk.mode_control_inputs <= (st_r == ST_PROG) ? MODE_INIT : MODE_RW;
         lnk.addr_latch_enable   <= (st_r == ST_IDLE && acc_req &&
                                     programmed_r && !rfr_pend_r &&
                                     !program_req && !refresh_req);
         lnk.cpu_addr            <= acc_addr[ADDR_W+1:2];
         lnk.refresh_cycle       <= (st_r == ST_RCLOSE) || (st_r == ST_REFR &&
                                                       rcnt_r != 2'h0);
         if (st_r == ST_PRECH || st_r == ST_RCLOSE)
            lnk.row_strobe_request_in <= 1'b0;
         else if (st_r == ST_ROW || (st_r == ST_REFR && rcnt_r != 2'h0))
            lnk.row_strobe_request_in <= 1'b1;
         else if (st_r == ST_REFR)
            lnk.row_strobe_request_in <= 1'b0;
         lnk.row_column_mux_select <= (st_r == ST_MUXC) ||
                                      (st_r == ST_STROBE) ||
                                      (st_r == ST_GAP && more) ||
                                      (st_r == ST_CHECK &&
                                       lnk.row_match_hit);
         lnk.column_strobe_byte_enables <= lanes_r;
         lnk.column_strobe_global_enable <= (st_r == ST_STROBE) &&
                                            !bank_r;
      end
   end

   // bank 1 strobes; refresh forced off since the buffer cannot
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         bank1_strobe_enables_r <= 4'h0;
      else if (st_r == ST_STROBE && bank_r && !lnk.refresh_cycle)
         bank1_strobe_enables_r <= lanes_r;
      else
         bank1_strobe_enables_r <= 4'h0;
   end

   // ----------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         acc_ack_r     <= 1'b0;
         refresh_ack_r <= 1'b0;
      end
      else
      begin
         acc_ack_r     <= (st_r == ST_GAP) && !more;
         refresh_ack_r <= (st_r == ST_RCLOSE);
      end
   end
endmodule
`default_nettype wire

// ### verification/tbd_link_properties.sv
// Purpose: link checks between the two strobe controller ends
// Assumes: one clock, async active high reset
// Notes:   sees only the shared link signals
`timescale 1ns/1ps
`default_nettype none
module tbd_link_properties
   import tbd_pkg::*;
(
   // clock and reset
   input wire logic             clk,
   input wire logic             sys_rst,
   // link
   input wire logic             row_strobe_request_in,
   input wire logic             column_strobe_global_enable,
   input wire logic             row_column_mux_select,
   input wire logic             addr_latch_enable,
   input wire logic             load_or_column_clock,
   input wire logic [1:0]       mode_control_inputs,
   input wire logic [CFG_W-1:0] address_config_inputs,
   input wire logic [1:0]       bank_select,
   input wire logic             refresh_cycle,
   input wire logic             row_match_hit
);
   // ----------
   // properties
   // ----------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // fixed wiring: any drift means a logic slip
   chk_bank_sel_low: assert property (bank_select == 2'h0)
      else $error("bank select not low");
   chk_cfg_top_low: assert property (!address_config_inputs[10])
      else $error("config top bit high");
   chk_cfg_value: assert property (
      address_config_inputs == {1'b0, CFG_PATTERN[12:3]})
      else $error("config pattern wrong");
   // a transparent latch would corrupt the column step
   chk_step_latch_low: assert property (
      $fell(load_or_column_clock) && mode_control_inputs == MODE_RW
      |-> !addr_latch_enable) else $error("column step with latch open");
   chk_hit_after_row: assert property (
      row_match_hit |-> $past(row_strobe_request_in))
      else $error("hit without row request");
   chk_row_then_col: assert property (
      $rose(row_strobe_request_in) && !refresh_cycle
      |=> $rose(row_column_mux_select)) else $error("column select late");
   chk_latch_no_strobe: assert property (addr_latch_enable
      |-> !row_column_mux_select && !column_strobe_global_enable)
      else $error("strobe while latch open");
   chk_init_no_access: assert property (
      mode_control_inputs == MODE_INIT
      |-> !column_strobe_global_enable && !row_column_mux_select)
      else $error("access during init mode");
endmodule
`default_nettype wire

// ### verification/two_bank_dram_strobe_control_tb.sv
// Purpose: bench for the controller and control logic pair
// Assumes: 25 MHz clock, reset held three cycles
// Notes:   lane order is the decoder's choice, so lane counts are checked
`timescale 1ns/1ps
`default_nettype none
module two_bank_dram_strobe_control_tb;
   import tbd_pkg::*;
   logic              clk = 1'b0;
   logic              sys_rst = 1'b1;
   logic              program_req = 1'b0;
   logic              refresh_req = 1'b0;
   logic              acc_req = 1'b0;
   logic              acc_write = 1'b0;
   logic [2:0]        acc_opt = 3'h0;
   logic [ADDR_W+1:0] acc_addr = 24'h000000;
   logic [3:0]        acc_beats = 4'h0;
   logic              acc_ack_r, programmed_r, refresh_ack_r, rs, rf;
   logic [LANES-1:0]  b1_r, ras_n_r, cas_n_r, cm, bm;
   logic [ROW_W-1:0]  dram_addr_r, ra;
   logic [CFG_W-1:0]  config_r;
   int                error_cnt = 0;
   int                total_checks = 0;
   int                n, k;
   tbd_link_if lnk ();
   always #20 clk = ~clk;
   tbd_dram_ctrl u_tbd_dram_ctrl (.clk(clk), .sys_rst(sys_rst),
      .lnk(lnk.ctrl), .ras_n_r(ras_n_r), .cas_n_r(cas_n_r),
      .dram_addr_r(dram_addr_r), .config_r(config_r));
   tbd_mem_seq u_tbd_mem_seq (.clk(clk), .sys_rst(sys_rst),
      .lnk(lnk.logic_end), .program_req(program_req),
      .refresh_req(refresh_req), .acc_req(acc_req), .acc_write(acc_write),
      .acc_opt(acc_opt), .acc_addr(acc_addr), .acc_beats(acc_beats),
      .acc_ack_r(acc_ack_r), .programmed_r(programmed_r),
      .refresh_ack_r(refresh_ack_r), .bank1_strobe_enables_r(b1_r));
   tbd_link_properties u_tbd_link_properties (.clk(clk), .sys_rst(sys_rst),
      .row_strobe_request_in(lnk.row_strobe_request_in),
      .column_strobe_global_enable(lnk.column_strobe_global_enable),
      .row_column_mux_select(lnk.row_column_mux_select),
      .addr_latch_enable(lnk.addr_latch_enable),
      .load_or_column_clock(lnk.load_or_column_clock),
      .mode_control_inputs(lnk.mode_control_inputs),
      .address_config_inputs(lnk.address_config_inputs),
      .bank_select(lnk.bank_select), .refresh_cycle(lnk.refresh_cycle),
      .row_match_hit(lnk.row_match_hit));
   task automatic compare(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // gather strobes each cycle until ack or the cycle limit
   task automatic run(input int lim);
      n = 0;
      cm = 4'h0;
      bm = 4'h0;
      rs = 1'b0;
      rf = 1'b0;
      k = 0;
      ra = '0;
      do
      begin
         @(posedge clk);
         #1;
         refresh_req = 1'b0;
         program_req = 1'b0;
         n++;
         cm |= ~cas_n_r;
         bm |= b1_r;
         rs |= (ras_n_r === 4'h0);
         rf |= refresh_ack_r;
         k += $countones(~cas_n_r) + $countones(b1_r);
         if (dram_addr_r > ra)
            ra = dram_addr_r;
      end
      while (acc_ack_r !== 1'b1 && n < lim);
      acc_req = 1'b0;
   endtask
   task automatic access(input logic w, input logic [2:0] o,
                         input logic [23:0] a, input logic [3:0] b);
      acc_write = w;
      acc_opt = o;
      acc_addr = a;
      acc_beats = b;
      acc_req = 1'b1;
      run(60);
   endtask
   // ---------
   // sequence
   // ---------
   initial
   begin
      repeat (3) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      compare("ras idle", 32'hf, ras_n_r);
      access(1'b0, OPT_WORD, 24'h000000, 4'h0);
      compare("early ack", 32'h3c, n);
      program_req = 1'b1;
      run(20);
      compare("config", {1'b0, CFG_PATTERN[12:3]}, config_r);
      access(1'b1, OPT_BYTE, 24'h000002, 4'h0);
      compare("miss cycles", 32'h8, n);
      compare("byte lanes", 32'h1, $countones(cm));
      compare("rows low", 32'h1, rs);
      access(1'b0, OPT_BYTE, 24'h000001, 4'h0);
      compare("hit cycles", 32'h5, n);
      compare("read lanes", 32'hf, cm);
      access(1'b1, OPT_HALF, 24'h000006, 4'h0);
      compare("bank1 lanes", 32'h2, $countones(bm));
      compare("bank0 quiet", 32'h0, cm);
      refresh_req = 1'b1;
      run(8);
      compare("refresh cas", 32'h0, {cm, bm});
      compare("refresh ras", 32'h3, {rs, rf});
      access(1'b0, OPT_WORD, 24'h000000, 4'h0);
      compare("after refresh", 32'h8, n);
      refresh_req = 1'b1;
      access(1'b0, OPT_WORD, 24'h000000, 4'h0);
      compare("refresh first", 32'h1, rf);
      access(1'b1, OPT_WORD, 24'h000000, 4'h3);
      compare("burst lanes", 32'hff, {cm, bm});
      // refresh cut in mid-burst: four beats of four lanes, none repeated
      acc_req = 1'b1;
      run(4);
      refresh_req = 1'b1;
      run(40);
      compare("cut burst strobes", 32'h10, k);
      compare("cut burst refresh", 32'h1, rf);
      compare("refresh row", 32'h2, ra);
      conclude();
   end
   initial
   begin
      #200000;
      error_cnt++;
      conclude();
   end
endmodule
`default_nettype wire
